// >>> src/tcc_core.v
// Capture/compare timer core: 16-bit counter, four general registers, four timer pins
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"

module tcc_core #(
  parameter CNT_W = 16
) (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire [`TCC_ADDR_W-1:0] reg_addr,
  input  wire [CNT_W-1:0]       reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [CNT_W-1:0]       reg_rdata,
  input  wire                   ext_clk_in,
  input  wire                   timer_pin_a_in,
  output wire                   timer_pin_a_out,
  output wire                   timer_pin_a_oe_n,
  input  wire                   timer_pin_b_in,
  output wire                   timer_pin_b_out,
  output wire                   timer_pin_b_oe_n,
  input  wire                   timer_pin_c_in,
  output wire                   timer_pin_c_out,
  output wire                   timer_pin_c_oe_n,
  input  wire                   timer_pin_d_in,
  output wire                   timer_pin_d_out,
  output wire                   timer_pin_d_oe_n,
  output wire                   irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  reg  [7:0]             timer_mode_register;
  reg  [7:0]             timer_control_register;
  reg  [7:0]             timer_irq_enable_register;
  reg  [7:0]             channel_ab_io_control;
  reg  [7:0]             channel_cd_io_control;
  reg  [CNT_W-1:0]       timer_up_counter;
  reg  [CNT_W-1:0]       gr [0:`TCC_NUM_CH-1];
  reg  [`TCC_NUM_CH-1:0] match_capture_flag;
  reg                    overflow_flag;
  reg  [`TCC_NUM_CH-1:0] flag_armed;
  reg                    ovf_armed;
  reg  [`TCC_PRE_W-1:0]  prescale;
  reg                    ext_prev;

  wire wr_mode   = reg_wr && (reg_addr == `TCC_OFF_MODE);
  wire wr_ctrl   = reg_wr && (reg_addr == `TCC_OFF_CTRL);
  wire wr_irq_en = reg_wr && (reg_addr == `TCC_OFF_IRQ_EN);
  wire wr_status = reg_wr && (reg_addr == `TCC_OFF_STATUS);
  wire wr_io_ab  = reg_wr && (reg_addr == `TCC_OFF_IO_AB);
  wire wr_io_cd  = reg_wr && (reg_addr == `TCC_OFF_IO_CD);
  wire wr_cnt    = reg_wr && (reg_addr == `TCC_OFF_COUNTER);
  wire rd_status = reg_rd && (reg_addr == `TCC_OFF_STATUS);

  wire [`TCC_NUM_CH-1:0] wr_gr;
  assign wr_gr[0] = reg_wr && (reg_addr == `TCC_OFF_GR_A);
  assign wr_gr[1] = reg_wr && (reg_addr == `TCC_OFF_GR_B);
  assign wr_gr[2] = reg_wr && (reg_addr == `TCC_OFF_GR_C);
  assign wr_gr[3] = reg_wr && (reg_addr == `TCC_OFF_GR_D);

  wire buf_a     = timer_mode_register[`TCC_MODE_BUF_A];
  wire buf_b     = timer_mode_register[`TCC_MODE_BUF_B];
  wire clr_on_a  = timer_control_register[`TCC_CTRL_CLR_A];
  wire [2:0] cks = timer_control_register[`TCC_CTRL_CKS_HI:`TCC_CTRL_CKS_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Counter clock source

  wire ext_rise = ext_clk_in && !ext_prev;
  reg  tick_src;

  always @* begin
    if (cks[`TCC_CKS_EXT_BIT]) begin
      tick_src = ext_rise;
    end else begin
      case (cks)
        `TCC_CKS_DIV1: tick_src = 1'b1;
        `TCC_CKS_DIV2: tick_src = (prescale[0] == 1'b1);
        `TCC_CKS_DIV4: tick_src = (prescale[1:0] == 2'h3);
        `TCC_CKS_DIV8: tick_src = (prescale == 3'h7);
        default:       tick_src = 1'b0;
      endcase
    end
  end

  // Count only while the run bit is set
  wire tick = tick_src && timer_mode_register[`TCC_MODE_RUN];
  // Prescaler free-runs, so the first divided tick after a start may come early
  wire [`TCC_PRE_W-1:0] next_prescale = prescale + {{(`TCC_PRE_W-1){1'b0}}, 1'b1};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= {`TCC_PRE_W{1'b0}};
      ext_prev <= 1'b0;
    end else begin
      prescale <= next_prescale;
      ext_prev <= ext_clk_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel compare, capture and pin logic

  wire [`TCC_NUM_CH-1:0] pin_in = {timer_pin_d_in, timer_pin_c_in,
                                   timer_pin_b_in, timer_pin_a_in};
  wire [4*`TCC_IO_FIELD_W-1:0] cfg = {channel_cd_io_control[6:4],
                                      channel_cd_io_control[2:0],
                                      channel_ab_io_control[6:4],
                                      channel_ab_io_control[2:0]};
  // A buffering register gives up its own compare and capture
  wire [`TCC_NUM_CH-1:0] live = {~buf_b, ~buf_a, 2'h3};

  wire [`TCC_NUM_CH-1:0] match;
  wire [`TCC_NUM_CH-1:0] capture;
  wire [`TCC_NUM_CH-1:0] pin_level;
  wire [`TCC_NUM_CH-1:0] pin_prev;
  wire [`TCC_NUM_CH-1:0] pin_drive;

  genvar ch;
  generate
    for (ch = 0; ch < `TCC_NUM_CH; ch = ch + 1) begin : g_ch
      reg        lvl;
      reg        prev;
      reg        next_lvl;
      wire       role = cfg[ch*`TCC_IO_FIELD_W + `TCC_IO_ROLE];
      wire [1:0] act  = cfg[ch*`TCC_IO_FIELD_W +: 2];
      wire       rise = pin_in[ch] && !pin_prev[ch];
      wire       fall = !pin_in[ch] && pin_prev[ch];
      wire       edge_hit;

      // Tick while equal: the match lands as the counter leaves the value
      assign match[ch] = tick && !role && live[ch] &&
                         (timer_up_counter == gr[ch]);
      // Edge select: 00 rising, 01 falling, 1X both
      assign edge_hit = act[`TCC_IO_ACT_HI] ? (rise || fall) :
                        (act[`TCC_IO_ACT_LO] ? fall : rise);
      assign capture[ch] = role && live[ch] && edge_hit;
      // Pin floats unless a compare action is chosen
      assign pin_drive[ch] = !role && (act != `TCC_ACT_NONE);

      // Forcing a level is idempotent, so no glitch at equal level
      always @* begin
        next_lvl = lvl;
        if (match[ch]) begin
          case (act)
            `TCC_ACT_LOW:    next_lvl = 1'b0;
            `TCC_ACT_HIGH:   next_lvl = 1'b1;
            `TCC_ACT_TOGGLE: next_lvl = ~lvl;
            default:         next_lvl = lvl;
          endcase
        end
      end

      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl  <= 1'b0;
          prev <= 1'b0;
        end else begin
          lvl  <= next_lvl;
          prev <= pin_in[ch];
        end
      end

      assign pin_level[ch] = lvl;
      assign pin_prev[ch]  = prev;
    end
  endgenerate

  assign timer_pin_a_out  = pin_level[0];
  assign timer_pin_b_out  = pin_level[1];
  assign timer_pin_c_out  = pin_level[2];
  assign timer_pin_d_out  = pin_level[3];
  assign timer_pin_a_oe_n = !pin_drive[0];
  assign timer_pin_b_oe_n = !pin_drive[1];
  assign timer_pin_c_oe_n = !pin_drive[2];
  assign timer_pin_d_oe_n = !pin_drive[3];

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  wire clear_now = match[0] && clr_on_a;
  wire wrap      = tick && !clear_now && (timer_up_counter == `TCC_CNT_MAX);

  reg  [CNT_W-1:0] next_counter;

  // Software write wins over clear and tick in the same cycle
  always @* begin
    next_counter = timer_up_counter;
    if (wr_cnt) begin
      next_counter = reg_wdata;
    end else if (clear_now) begin
      next_counter = `TCC_RST_COUNTER;
    end else if (tick) begin
      next_counter = timer_up_counter + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_up_counter <= `TCC_RST_COUNTER;
    end else begin
      timer_up_counter <= next_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General registers with buffer chaining; pairs A/C and B/D

  integer i;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `TCC_NUM_CH; i = i + 1) begin
        gr[i] <= `TCC_RST_GR;
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        // Software write wins over a same-cycle hardware update
        if (wr_gr[i]) begin
          gr[i] <= reg_wdata;
        end else if (capture[i]) begin
          gr[i] <= timer_up_counter;
        end else if (match[i] && !live[i+2]) begin
          gr[i] <= gr[i+2];
        end
        if (wr_gr[i+2]) begin
          gr[i+2] <= reg_wdata;
        end else if (capture[i] && !live[i+2]) begin
          gr[i+2] <= gr[i];
        end else if (capture[i+2]) begin
          gr[i+2] <= timer_up_counter;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: read-as-one arms the clear, set beats clear

  wire [`TCC_NUM_CH-1:0] flag_set = match | capture;
  wire [`TCC_NUM_CH-1:0] flag_clr = {`TCC_NUM_CH{wr_status}} & flag_armed &
                                    ~reg_wdata[`TCC_NUM_CH-1:0];
  wire ovf_clr = wr_status && ovf_armed && !reg_wdata[`TCC_FLAG_OVF];
  wire [`TCC_NUM_CH-1:0] next_flag = (match_capture_flag & ~flag_clr) | flag_set;
  wire                   next_ovf  = (overflow_flag && !ovf_clr) || wrap;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_capture_flag <= {`TCC_NUM_CH{1'b0}};
      overflow_flag      <= 1'b0;
      flag_armed         <= {`TCC_NUM_CH{1'b0}};
      ovf_armed          <= 1'b0;
    end else begin
      match_capture_flag <= next_flag;
      overflow_flag      <= next_ovf;
      if (rd_status) begin
        flag_armed <= match_capture_flag;
        ovf_armed  <= overflow_flag;
      end else if (wr_status) begin
        // One read arms one clear attempt only
        flag_armed <= {`TCC_NUM_CH{1'b0}};
        ovf_armed  <= 1'b0;
      end
    end
  end

  // Plain OR of enabled flags; software finds the cause in the status register
  wire [`TCC_NUM_CH-1:0] chan_irq = match_capture_flag &
                                    timer_irq_enable_register[`TCC_NUM_CH-1:0];
  wire                   ovf_irq  = overflow_flag &&
                                    timer_irq_enable_register[`TCC_FLAG_OVF];

  assign irq_req = |chan_irq || ovf_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_register       <= `TCC_RST_BYTE;
      timer_control_register    <= `TCC_RST_BYTE;
      timer_irq_enable_register <= `TCC_RST_BYTE;
      channel_ab_io_control     <= `TCC_RST_IO;
      channel_cd_io_control     <= `TCC_RST_IO;
    end else begin
      if (wr_mode) begin
        timer_mode_register <= reg_wdata[7:0];
      end
      if (wr_ctrl) begin
        timer_control_register <= reg_wdata[7:0];
      end
      if (wr_irq_en) begin
        timer_irq_enable_register <= reg_wdata[7:0];
      end
      // Reserved bits are held at one regardless of the write
      if (wr_io_ab) begin
        channel_ab_io_control <= reg_wdata[7:0] | `TCC_IO_RSV_MASK;
      end
      if (wr_io_cd) begin
        channel_cd_io_control <= reg_wdata[7:0] | `TCC_IO_RSV_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stands one cycle after the strobe only

  reg  [CNT_W-1:0] next_rdata;
  wire [7:0]       status_byte = {overflow_flag, 3'h0, match_capture_flag};
  wire [7:0]       io_ab_rd    = channel_ab_io_control | `TCC_IO_RSV_MASK;
  wire [7:0]       io_cd_rd    = channel_cd_io_control | `TCC_IO_RSV_MASK;

  always @* begin
    next_rdata = {CNT_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `TCC_OFF_MODE:    next_rdata = {8'h00, timer_mode_register};
        `TCC_OFF_CTRL:    next_rdata = {8'h00, timer_control_register};
        `TCC_OFF_IRQ_EN:  next_rdata = {8'h00, timer_irq_enable_register};
        `TCC_OFF_STATUS:  next_rdata = {8'h00, status_byte};
        `TCC_OFF_IO_AB:   next_rdata = {8'h00, io_ab_rd};
        `TCC_OFF_IO_CD:   next_rdata = {8'h00, io_cd_rd};
        `TCC_OFF_COUNTER: next_rdata = timer_up_counter;
        `TCC_OFF_GR_A:    next_rdata = gr[0];
        `TCC_OFF_GR_B:    next_rdata = gr[1];
        `TCC_OFF_GR_C:    next_rdata = gr[2];
        `TCC_OFF_GR_D:    next_rdata = gr[3];
        default:          next_rdata = {CNT_W{1'b0}};
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {CNT_W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> src/tcc_regs.vh
// Register map, field positions and reset values of the capture/compare timer core
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// Word offsets on the register port
`define TCC_ADDR_W        4
`define TCC_OFF_MODE      4'h0
`define TCC_OFF_CTRL      4'h1
`define TCC_OFF_IRQ_EN    4'h2
`define TCC_OFF_STATUS    4'h3
`define TCC_OFF_IO_AB     4'h4
`define TCC_OFF_IO_CD     4'h5
`define TCC_OFF_COUNTER   4'h6
`define TCC_OFF_GR_A      4'h7
`define TCC_OFF_GR_B      4'h8
`define TCC_OFF_GR_C      4'h9
`define TCC_OFF_GR_D      4'hA

// Mode register fields
`define TCC_MODE_RUN      7
`define TCC_MODE_BUF_B    1
`define TCC_MODE_BUF_A    0

// Control register fields
`define TCC_CTRL_CLR_A    7
`define TCC_CTRL_CKS_HI   6
`define TCC_CTRL_CKS_LO   4

// Status and enable fields: bits 3:0 are channels A..D
`define TCC_FLAG_OVF      7
`define TCC_NUM_CH        4

// Channel control fields, high channel in the upper nibble
`define TCC_IO_RSV_HI     7
`define TCC_IO_RSV_LO     3
`define TCC_IO_FIELD_W    3
`define TCC_IO_ROLE       2
`define TCC_IO_ACT_HI     1
`define TCC_IO_ACT_LO     0
`define TCC_IO_RSV_MASK   8'h88

// Pin actions in compare role
`define TCC_ACT_NONE      2'h0
`define TCC_ACT_LOW       2'h1
`define TCC_ACT_HIGH      2'h2
`define TCC_ACT_TOGGLE    2'h3

// Clock select codes
`define TCC_CKS_DIV1      3'h0
`define TCC_CKS_DIV2      3'h1
`define TCC_CKS_DIV4      3'h2
`define TCC_CKS_DIV8      3'h3
`define TCC_CKS_EXT_BIT   2

// Reset values
`define TCC_RST_COUNTER   16'h0000
`define TCC_RST_GR        16'hFFFF
`define TCC_RST_BYTE      8'h00
`define TCC_RST_IO        8'h88
`define TCC_CNT_MAX       16'hFFFF
`define TCC_PRE_W         3

`endif

// >>> verification/tcc_core_properties.sv
// Checker for the timer core's control readback, pin enables, pin actions and interrupt line
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_chk #(
  parameter CNT_W = 16
) (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire logic [`TCC_ADDR_W-1:0] reg_addr,
  input wire logic [CNT_W-1:0]       reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [CNT_W-1:0]       reg_rdata,
  input wire logic                   timer_pin_c_out,
  input wire logic                   timer_pin_c_oe_n,
  input wire logic                   timer_pin_d_out,
  input wire logic                   timer_pin_d_oe_n,
  input wire logic                   irq_req
);
  // Shadows built from the write strobe only, so a stuck design register shows up
  logic [7:0] io_sh;
  logic [7:0] mode_sh;
  logic [7:0] en_sh;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_sh   <= `TCC_RST_IO;
      mode_sh <= `TCC_RST_BYTE;
      en_sh   <= `TCC_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `TCC_OFF_IO_CD) io_sh <= reg_wdata[7:0];
      if (reg_addr == `TCC_OFF_MODE) mode_sh <= reg_wdata[7:0];
      if (reg_addr == `TCC_OFF_IRQ_EN) en_sh <= reg_wdata[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_io_read;
    reg_rd && reg_addr == `TCC_OFF_IO_CD ##1 1'b1;
  endsequence
  sequence s_c_low_held;
    (io_sh[2:0] == 3'b001) [*2];
  endsequence
  sequence s_d_high_held;
    (io_sh[6:4] == 3'b010) [*2];
  endsequence
  a_io_rsv_ones: assert property (s_io_read |-> reg_rdata[7] && reg_rdata[3])
    else $error("reserved control bits not read as one");
  a_c_oe_role: assert property (
    !mode_sh[0] |-> timer_pin_c_oe_n == (io_sh[2] || io_sh[1:0] == 2'b00))
    else $error("pin c enable does not follow its role");
  a_d_oe_role: assert property (
    !mode_sh[1] |-> timer_pin_d_oe_n == (io_sh[6] || io_sh[5:4] == 2'b00))
    else $error("pin d enable does not follow its role");
  a_irq_masked: assert property ((en_sh & 8'h8F) == 8'h00 |-> !irq_req)
    else $error("interrupt request with all enables off");
  a_c_low_only: assert property (s_c_low_held |-> !$rose(timer_pin_c_out))
    else $error("pin c rose under drive-low action");
  a_d_high_only: assert property (s_d_high_held |-> !$fell(timer_pin_d_out))
    else $error("pin d fell under drive-high action");
  a_c_none_hold: assert property ((io_sh[2:0] == 3'b000) [*2] |-> $stable(timer_pin_c_out))
    else $error("pin c moved with no action selected");
  a_d_cap_hold: assert property (io_sh[6] [*2] |-> $stable(timer_pin_d_out))
    else $error("pin d output moved in capture role");
endmodule
bind tcc_core tcc_chk #(.CNT_W(CNT_W)) tcc_chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer_pin_c_out(timer_pin_c_out), .timer_pin_c_oe_n(timer_pin_c_oe_n),
  .timer_pin_d_out(timer_pin_d_out), .timer_pin_d_oe_n(timer_pin_d_oe_n), .irq_req(irq_req)
);
`default_nettype wire

// >>> verification/tcc_pin_model.sv
// Far-side model of the four timer pins
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model (
  input wire logic [3:0] drive_lvl,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic     [3:0] pin_lvl
);
  // Core wins while it drives; the far side only drives a floated pin
  assign pin_lvl = (pin_oe_n & drive_lvl) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// >>> verification/test_timer_capture_compare_core.sv
// Self-checking bench for the capture/compare timer core
`timescale 1ns/10ps
`default_nettype none
`include "tcc_regs.vh"
module test_timer_capture_compare_core;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_clk_in = 1'b0;
  logic [3:0]  drive_lvl = 4'h0;
  wire  [15:0] reg_rdata;
  wire  [3:0]  pin_out;
  wire  [3:0]  pin_oe_n;
  wire  [3:0]  pin_lvl;
  wire         irq_req;
  logic [15:0] exp_q[$];
  logic        rd_seen = 1'b0;
  int          error_cnt = 0;
  int          check_count = 0;
  int          seed = 65320;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [15:0] g;
  logic [1:0]  act [5] = '{2'h2, 2'h1, 2'h1, 2'h3, 2'h3};
  logic        pin_exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  always #25 core_clk = ~core_clk;
  tcc_core tcc_core_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
    .timer_pin_a_in(pin_lvl[0]), .timer_pin_a_out(pin_out[0]), .timer_pin_a_oe_n(pin_oe_n[0]),
    .timer_pin_b_in(pin_lvl[1]), .timer_pin_b_out(pin_out[1]), .timer_pin_b_oe_n(pin_oe_n[1]),
    .timer_pin_c_in(pin_lvl[2]), .timer_pin_c_out(pin_out[2]), .timer_pin_c_oe_n(pin_oe_n[2]),
    .timer_pin_d_in(pin_lvl[3]), .timer_pin_d_out(pin_out[3]), .timer_pin_d_oe_n(pin_oe_n[3]),
    .irq_req(irq_req)
  );
  tcc_pin_model tcc_pin_model_i (
    .drive_lvl(drive_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // Whole 16-bit words only; strobes stay up between back-to-back accesses
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] want);
    exp_q.push_back(want);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen) check(reg_rdata, exp_q.pop_front());
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`TCC_OFF_COUNTER, 16'h0000);
    for (int i = 0; i < 4; i++) rd(4'(`TCC_OFF_GR_A + i), `TCC_RST_GR);
    wr(`TCC_OFF_IO_CD, 16'h0000);
    rd(`TCC_OFF_IO_CD, 16'h0088);
    v1 = 16'($random(seed)) | 16'h8000;
    v2 = 16'($random(seed));
    wr(`TCC_OFF_GR_B, v1);
    wr(`TCC_OFF_COUNTER, v2);
    rd(`TCC_OFF_GR_B, v1);
    rd(`TCC_OFF_COUNTER, v2);
    idle(2);
    $display("register test done");
    wr(`TCC_OFF_IRQ_EN, 16'h0004);
    for (int i = 0; i < 5; i++) begin
      wr(`TCC_OFF_MODE, 16'h0000);
      wr(`TCC_OFF_COUNTER, 16'h0000);
      wr(`TCC_OFF_GR_C, 16'h000A);
      wr(`TCC_OFF_IO_CD, 16'(act[i]));
      wr(`TCC_OFF_MODE, 16'h0080);
      idle(15);
      wr(`TCC_OFF_MODE, 16'h0000);
      idle(1);
      check(16'(pin_lvl[2]), 16'(pin_exp[i]));
      check(16'(irq_req), 16'h0001);
      wr(`TCC_OFF_STATUS, 16'h0000);
      rd(`TCC_OFF_STATUS, 16'h0004);
      wr(`TCC_OFF_STATUS, 16'h0000);
      rd(`TCC_OFF_STATUS, 16'h0000);
      idle(2);
      check(16'(irq_req), 16'h0000);
    end
    $display("compare test done");
    wr(`TCC_OFF_COUNTER, 16'h0000);
    wr(`TCC_OFF_GR_A, 16'h0005);
    wr(`TCC_OFF_GR_B, 16'h0007);
    wr(`TCC_OFF_CTRL, 16'h0080);
    wr(`TCC_OFF_MODE, 16'h0080);
    idle(40);
    wr(`TCC_OFF_MODE, 16'h0000);
    wr(`TCC_OFF_CTRL, 16'h0000);
    rd(`TCC_OFF_COUNTER, 16'h0005);
    rd(`TCC_OFF_STATUS, 16'h0001);
    wr(`TCC_OFF_STATUS, 16'h0000);
    for (int i = 0; i < 4; i++) wr(4'(`TCC_OFF_GR_A + i), 16'h8000);
    wr(`TCC_OFF_IRQ_EN, 16'h0080);
    wr(`TCC_OFF_COUNTER, 16'hFFF0);
    wr(`TCC_OFF_MODE, 16'h0080);
    idle(30);
    wr(`TCC_OFF_MODE, 16'h0000);
    rd(`TCC_OFF_STATUS, 16'h0080);
    idle(1);
    check(16'(irq_req), 16'h0001);
    wr(`TCC_OFF_IRQ_EN, 16'h0000);
    $display("counter test done");
    for (int c = 0; c < 3; c++) begin
      drive_lvl[3] <= 1'b1;
      idle(3);
      wr(`TCC_OFF_IO_CD, 16'h0040 | 16'(c << 4));
      v1 = 16'($random(seed));
      wr(`TCC_OFF_COUNTER, v1);
      wr(`TCC_OFF_GR_D, 16'h1234);
      idle(2);
      drive_lvl[3] <= 1'b0;
      idle(4);
      g = (c == 0) ? 16'h1234 : v1;
      rd(`TCC_OFF_GR_D, g);
      v2 = 16'($random(seed));
      wr(`TCC_OFF_COUNTER, v2);
      idle(1);
      drive_lvl[3] <= 1'b1;
      idle(4);
      rd(`TCC_OFF_GR_D, (c == 1) ? g : v2);
    end
    $display("capture test done");
    wr(`TCC_OFF_MODE, 16'h0001);
    wr(`TCC_OFF_IO_AB, 16'h0004);
    wr(`TCC_OFF_GR_A, 16'h1111);
    v1 = 16'($random(seed));
    wr(`TCC_OFF_COUNTER, v1);
    idle(2);
    drive_lvl[0] <= 1'b1;
    idle(4);
    rd(`TCC_OFF_GR_A, v1);
    rd(`TCC_OFF_GR_C, 16'h1111);
    wr(`TCC_OFF_IO_AB, 16'h0000);
    wr(`TCC_OFF_GR_A, 16'h0003);
    wr(`TCC_OFF_GR_C, 16'h0009);
    wr(`TCC_OFF_COUNTER, 16'h0000);
    wr(`TCC_OFF_MODE, 16'h0081);
    idle(10);
    wr(`TCC_OFF_MODE, 16'h0000);
    rd(`TCC_OFF_GR_A, 16'h0009);
    wr(`TCC_OFF_MODE, 16'h0002);
    wr(`TCC_OFF_IRQ_EN, 16'h0002);
    wr(`TCC_OFF_IO_AB, 16'h0040);
    wr(`TCC_OFF_GR_B, 16'h2222);
    v1 = 16'($random(seed));
    wr(`TCC_OFF_COUNTER, v1);
    idle(2);
    check(16'(irq_req), 16'h0000);
    drive_lvl[1] <= 1'b1;
    idle(4);
    check(16'(irq_req), 16'h0001);
    rd(`TCC_OFF_GR_B, v1);
    rd(`TCC_OFF_GR_D, 16'h2222);
    wr(`TCC_OFF_IRQ_EN, 16'h0000);
    idle(3);
    $display("buffer test done");
    drive_lvl[3] <= 1'b0;
    wr(`TCC_OFF_IO_CD, 16'h0020);
    wr(`TCC_OFF_GR_D, 16'h0004);
    wr(`TCC_OFF_COUNTER, 16'h0000);
    wr(`TCC_OFF_MODE, 16'h0080);
    idle(8);
    wr(`TCC_OFF_MODE, 16'h0000);
    idle(1);
    check(16'(pin_lvl[3]), 16'h0001);
    check(16'(pin_out), 16'h0008);
    check(16'(pin_oe_n), 16'h0007);
    for (int k = 0; k < 4; k++) begin
      wr(`TCC_OFF_CTRL, 16'(k << 4));
      wr(`TCC_OFF_COUNTER, 16'h0000);
      wr(`TCC_OFF_MODE, 16'h0080);
      idle(15);
      wr(`TCC_OFF_MODE, 16'h0000);
      rd(`TCC_OFF_COUNTER, 16'(16 >> k));
    end
    wr(`TCC_OFF_CTRL, 16'h0040);
    wr(`TCC_OFF_COUNTER, 16'h0000);
    wr(`TCC_OFF_MODE, 16'h0080);
    repeat (3) begin
      ext_clk_in <= 1'b1;
      idle(2);
      ext_clk_in <= 1'b0;
      idle(2);
    end
    wr(`TCC_OFF_MODE, 16'h0000);
    wr(`TCC_OFF_CTRL, 16'h0000);
    rd(`TCC_OFF_COUNTER, 16'h0003);
    idle(3);
    $display("clock test done");
    summarize();
  end
endmodule
`default_nettype wire
